// ### rtl/ppc_pkg.sv
/*
 * Constants, field positions, reset values and carrier types for the
 * port pin control block.
 * Assumes one 200 MHz clock, a synchronous active-high reset and an
 * AXI4-Lite register bus with 32-bit data.
 */
package ppc_pkg;

    // ************************************************************
    // Port geometry
    // ************************************************************
    localparam int NPORT = 10;          // Ports 0-7, 12, 13
    localparam int NIRQ = 7;            // External interrupt inputs
    localparam int AW = 12;             // Register bus address width
    localparam int P_IRQ = 0;           // Port carrying interrupt pins
    localparam int P_AN = 1;            // Port shared with analog inputs
    localparam int P_AD = 4;            // Low address/data port
    localparam int P_HA = 5;            // High address port
    localparam int P_CTL = 6;           // Strobe and open-drain port
    // Implemented pins per port, index 9 first
    localparam logic [NPORT-1:0][7:0] PORT_MASK = {
        8'h03, 8'hff, 8'h07, 8'hff, 8'hff,
        8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
    // Input-only pins
    localparam logic [NPORT-1:0][7:0] PORT_IN_ONLY = {
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h81};
    // Open-drain pins
    localparam logic [NPORT-1:0][7:0] PORT_OD = {
        8'h00, 8'h00, 8'h00, 8'h0f, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam int SUB_OSC_PIN = 7;     // Oscillator pin within port 0
    localparam int WAIT_PIN = 6;        // Wait input within port 6

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [3:0] PAGE_PORT = 4'h0;  // Per-port page
    localparam logic [3:0] PAGE_GLB = 4'h1;   // Global page
    localparam logic [1:0] OFF_DATA = 2'h0;   // Latch / readback
    localparam logic [1:0] OFF_DIR = 2'h1;    // Direction, 1 = input
    localparam logic [1:0] OFF_PUE = 2'h2;    // Pull-up enable
    localparam logic [2:0] G_CTRL = 3'h0;     // Mode control
    localparam logic [2:0] G_FLAG = 3'h1;     // Test flag, write 1 clears
    localparam logic [2:0] G_RISE = 3'h2;     // Rising edge enables
    localparam logic [2:0] G_FALL = 3'h3;     // Falling edge enables
    localparam logic [2:0] G_PCC = 3'h4;      // Processor clock control
    localparam int CTRL_MEXP = 0;             // Memory expansion active
    localparam int CTRL_ADC = 1;              // Port 1 in analog use
    localparam int PCC_FRC = 6;               // Feedback cut bit

    // ************************************************************
    // Reset values and responses
    // ************************************************************
    localparam logic [7:0] DIR_RST = 8'hff;
    localparam logic [7:0] LAT_RST = 8'h00;
    localparam logic [7:0] PUE_RST = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************************
    // Carrier types
    // ************************************************************
    typedef struct packed {
        logic [7:0] dout;   // Level driven when enabled
        logic [7:0] oe_n;   // Low while the pin is driven
        logic [7:0] pull;   // Pull-up connected
    } ppc_pad_s;

    typedef struct packed {
        logic [15:0] addr;  // External address
        logic [7:0] ad_out; // Data to drive on the low bus
        logic ad_oe;        // Drive the low bus
        logic rd;           // Read strobe level
        logic wr;           // Write strobe level
        logic address_latch_strobe;         // Address latch strobe level
    } ppc_ext_s;

endpackage

// ### rtl/ppc_port_bank.sv
/*
 * One port: works out pad drive, pull-up and readback from latch,
 * direction, pull-up enable and alternate-function requests.
 * Purely combinational; the caller registers the results.
 */
`timescale 1ns/1ps
module ppc_port_bank #(
    parameter logic [7:0] VALID = 8'hff,
    parameter logic [7:0] IN_ONLY = 8'h00,
    parameter logic [7:0] OD = 8'h00,
    parameter logic [7:0] OD_PU = 8'h00
) (
    // Software state
    input wire logic [7:0] lat,
    input wire logic [7:0] dir,
    input wire logic [7:0] pue,
    input wire logic pu_kill,
    // Alternate function
    input wire logic [7:0] alt_en,
    input wire logic [7:0] alt_out,
    input wire logic [7:0] alt_oe,
    // Pin side
    input wire logic [7:0] pin_in,
    output ppc_pkg::ppc_pad_s pad_nxt,
    output logic [7:0] rd_val
);
    import ppc_pkg::*;

    logic [7:0] drv; // Pins actively driven
    logic [7:0] val; // Level chosen for each pin

    // Pad control for every pin of the port
    always_comb begin
        val = (alt_en & alt_out) | (~alt_en & lat);
        drv = ((alt_en & alt_oe) | (~alt_en & ~dir)) & VALID & ~IN_ONLY;
        pad_nxt.dout = val & ~OD & VALID;
        // Open-drain pins only ever pull low
        pad_nxt.oe_n = ~(drv & (~OD | ~val));
        pad_nxt.pull = ~drv & pue & ~OD & ~IN_ONLY & VALID & {8{!pu_kill}};
        pad_nxt.pull = pad_nxt.pull | (OD_PU & OD);
        rd_val = ((dir & pin_in) | (~dir & lat)) & VALID;
    end

endmodule

// ### rtl/ppc_edge_det.sv
/*
 * Edge detectors for the external interrupt inputs with per-input
 * rising and falling enables; one-cycle request pulses.
 * Inputs are synchronous to ref_clk.
 */
`timescale 1ns/1ps
module ppc_edge_det (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Pins and edge selection
    input wire logic [ppc_pkg::NIRQ-1:0] pin,
    input wire logic [ppc_pkg::NIRQ-1:0] rise_en,
    input wire logic [ppc_pkg::NIRQ-1:0] fall_en,
    // Requests
    output logic [ppc_pkg::NIRQ-1:0] irq_req
);
    import ppc_pkg::*;

    logic [NIRQ-1:0] prev_r, irq_r, irq_nxt; // Last level, pulses
    logic arm_r;                            // Prev holds a real sample

    // ************************************************************
    // Per-input detection
    // ************************************************************
    for (genvar k = 0; k < NIRQ; k++) begin : g_irq
        always_comb begin
            irq_nxt[k] = arm_r && ((rise_en[k] && pin[k] && !prev_r[k])
                || (fall_en[k] && !pin[k] && prev_r[k]));
        end
    end

    // Registers; no edge is seen on the first cycle after reset
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            prev_r <= '0;
            irq_r <= '0;
            arm_r <= 1'b0;
        end else begin
            prev_r <= pin;
            irq_r <= irq_nxt;
            arm_r <= 1'b1;
        end
    end

    assign irq_req = irq_r;

    // Pulse only where the pin changed between the two samples
    AST_IRQ_EDGE: assert property (@(posedge ref_clk) disable iff (srst)
        irq_r != '0 |-> (irq_r & ~($past(pin, 2) ^ $past(pin))) == '0)
        else $error("interrupt pulse without a pin edge");

endmodule

// ### rtl/ppc_top.sv
/*
 * Port pin control: register file over AXI4-Lite, per-port pad logic,
 * memory expansion sharing, test flag and interrupt edge detection.
 * Pins are sampled as synchronous to ref_clk; the pad ring resolves
 * drive from dout and the active-low enable.
 */
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module ppc_top #(
    parameter logic [3:0] OD_PULLUP = 4'h0  // Mask choice per pin
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // AXI4-Lite write
    input wire logic [ppc_pkg::AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [ppc_pkg::AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pads
    input wire logic [ppc_pkg::NPORT-1:0][7:0] pin_in,
    output ppc_pkg::ppc_pad_s [ppc_pkg::NPORT-1:0] pad_o,
    // External memory bus
    input ppc_pkg::ppc_ext_s ext_i,
    output logic [7:0] ext_ad_in,
    output logic ext_wait,
    // Status and side signals
    output logic [ppc_pkg::NIRQ-1:0] ext_irq_inputs,
    output logic port_edge_test_flag,
    output logic sub_osc_feedback_cut
);
    import ppc_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    // Bus handshake state
    logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
    logic awready_r, awready_nxt, wready_r, wready_nxt;
    logic bvalid_r, bvalid_nxt, arready_r, arready_nxt;
    logic rvalid_r, rvalid_nxt, wbyte_r, wbyte_nxt;
    logic [AW-1:0] awaddr_r, awaddr_nxt;
    logic [7:0] wdata_r, wdata_nxt, rd_word;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic do_wr; // Both halves of a write are held
    // Configuration registers
    logic [NPORT-1:0][7:0] lat_r, lat_nxt, dir_r, dir_nxt;
    logic [NPORT-1:0][7:0] pue_r, pue_nxt;
    logic [1:0] ctrl_r, ctrl_nxt;
    logic [NIRQ-1:0] rise_r, rise_nxt, fall_r, fall_nxt;
    logic [7:0] pcc_r, pcc_nxt;
    logic flag_r, flag_nxt;
    // Pad state
    logic [NPORT-1:0][7:0] alt_en, alt_out, alt_oe, rd_v;
    ppc_pad_s [NPORT-1:0] pad_r, pad_nxt;
    logic [7:0] p4_prev_r, ad_in_r;
    logic wait_r;
    logic [3:0] pidx; // Port addressed by the write

    // Address decode: port page or global page
    function automatic logic addr_ok(input logic [AW-1:0] a);
        if (a[AW-1:8] == PAGE_PORT) begin
            addr_ok = (a[7:4] < 4'(NPORT)) && (a[3:2] <= OFF_PUE);
        end else begin
            addr_ok = (a[AW-1:8] == PAGE_GLB) && (a[7:5] == 3'h0)
                && (a[4:2] <= G_PCC);
        end
    endfunction

    // ************************************************************
    // Bus slave
    // ************************************************************
    assign do_wr = aw_got_r && w_got_r && !bvalid_r;

    // Read data selection
    always_comb begin
        rd_word = 8'h00;
        if (s_axi_araddr[AW-1:8] == PAGE_PORT) begin
            case (s_axi_araddr[3:2])
                OFF_DATA: rd_word = rd_v[s_axi_araddr[7:4]];
                OFF_DIR: rd_word = dir_r[s_axi_araddr[7:4]];
                OFF_PUE: rd_word = pue_r[s_axi_araddr[7:4]];
                default: rd_word = 8'h00;
            endcase
        end else begin
            case (s_axi_araddr[4:2])
                G_CTRL: rd_word = {6'h00, ctrl_r};
                G_FLAG: rd_word = {7'h00, flag_r};
                G_RISE: rd_word = {1'b0, rise_r};
                G_FALL: rd_word = {1'b0, fall_r};
                G_PCC: rd_word = pcc_r;
                default: rd_word = 8'h00;
            endcase
        end
    end

    // Handshake next state
    always_comb begin
        aw_got_nxt = aw_got_r;
        w_got_nxt = w_got_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wbyte_nxt = wbyte_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        // Address and data are taken in either order
        if (s_axi_awvalid && awready_r) begin
            aw_got_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_r) begin
            w_got_nxt = 1'b1;
            wdata_nxt = s_axi_wdata[7:0];
            wbyte_nxt = s_axi_wstrb[0];
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        // Commit and answer once both halves are in
        if (do_wr) begin
            bvalid_nxt = 1'b1;
            bresp_nxt = addr_ok(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
            aw_got_nxt = 1'b0;
            w_got_nxt = 1'b0;
        end
        awready_nxt = !aw_got_nxt && !bvalid_nxt;
        wready_nxt = !w_got_nxt && !bvalid_nxt;
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && arready_r) begin
            rvalid_nxt = 1'b1;
            // Unmapped reads return zero data along with the error
            rdata_nxt = {24'h000000, addr_ok(s_axi_araddr) ? rd_word : 8'h00};
            rresp_nxt = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        arready_nxt = !rvalid_nxt;
    end

    // Handshake registers
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= 8'h00;
            wbyte_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= RESP_OKAY;
        end else begin
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wbyte_r <= wbyte_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    assign pidx = awaddr_r[7:4];

    // Register writes and the test flag
    always_comb begin
        lat_nxt = lat_r;
        dir_nxt = dir_r;
        pue_nxt = pue_r;
        ctrl_nxt = ctrl_r;
        rise_nxt = rise_r;
        fall_nxt = fall_r;
        pcc_nxt = pcc_r;
        flag_nxt = flag_r;
        if (do_wr && wbyte_r && addr_ok(awaddr_r)) begin
            if (awaddr_r[AW-1:8] == PAGE_PORT) begin
                case (awaddr_r[3:2])
                    OFF_DATA: lat_nxt[pidx] = wdata_r & PORT_MASK[pidx];
                    // port 4 direction as one unit
                    OFF_DIR: dir_nxt[pidx] = (pidx == 4'(P_AD)) ? {8{wdata_r[0]}}
                        : wdata_r | ~PORT_MASK[pidx] | PORT_IN_ONLY[pidx];
                    OFF_PUE: pue_nxt[pidx] = wdata_r & PORT_MASK[pidx];
                    default: pue_nxt = pue_r;
                endcase
            end else begin
                case (awaddr_r[4:2])
                    G_CTRL: ctrl_nxt = wdata_r[1:0];
                    G_FLAG: flag_nxt = flag_r && !wdata_r[0];
                    G_RISE: rise_nxt = wdata_r[NIRQ-1:0];
                    G_FALL: fall_nxt = wdata_r[NIRQ-1:0];
                    G_PCC: pcc_nxt = wdata_r;
                    default: pcc_nxt = pcc_r;
                endcase
            end
        end
        if ((p4_prev_r & ~pin_in[P_AD]) != 8'h00) begin
            flag_nxt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            lat_r <= {NPORT{LAT_RST}};
            dir_r <= {NPORT{DIR_RST}};
            pue_r <= {NPORT{PUE_RST}};
            ctrl_r <= 2'h0;
            rise_r <= '0;
            fall_r <= '0;
            pcc_r <= 8'h00;
            flag_r <= 1'b0;
        end else begin
            lat_r <= lat_nxt;
            dir_r <= dir_nxt;
            pue_r <= pue_nxt;
            ctrl_r <= ctrl_nxt;
            rise_r <= rise_nxt;
            fall_r <= fall_nxt;
            pcc_r <= pcc_nxt;
            flag_r <= flag_nxt;
        end
    end

    // ************************************************************
    // Pad logic
    // ************************************************************
    // Alternate functions while expansion is active
    always_comb begin
        alt_en = '0;
        alt_out = '0;
        alt_oe = '0;
        if (ctrl_r[CTRL_MEXP]) begin
            alt_en[P_AD] = 8'hff;
            alt_out[P_AD] = ext_i.ad_out;
            alt_oe[P_AD] = {8{ext_i.ad_oe}};
            alt_en[P_CTL] = 8'hf0;
            alt_out[P_CTL] = {ext_i.address_latch_strobe, 1'b0, ext_i.wr, ext_i.rd, 4'h0};
            alt_oe[P_CTL] = 8'hb0;
            alt_en[P_HA] = 8'hff;
            alt_out[P_HA] = ext_i.addr[15:8];
            alt_oe[P_HA] = 8'hff;
        end
    end

    for (genvar g = 0; g < NPORT; g++) begin : g_bank
        ppc_port_bank #(
            .VALID(PORT_MASK[g]),
            .IN_ONLY(PORT_IN_ONLY[g]),
            .OD(PORT_OD[g]),
            .OD_PU({4'h0, OD_PULLUP})
        ) u_bank (
            .lat(lat_r[g]),
            .dir(dir_r[g]),
            .pue(pue_r[g]),
            .pu_kill(g == P_AN && ctrl_r[CTRL_ADC]),
            .alt_en(alt_en[g]),
            .alt_out(alt_out[g]),
            .alt_oe(alt_oe[g]),
            .pin_in(pin_in[g]),
            .pad_nxt(pad_nxt[g]),
            .rd_val(rd_v[g])
        );
    end

    // Pad and sampled-pin registers
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pad_r <= {NPORT{24'h00ff00}};
            p4_prev_r <= 8'h00;
            ad_in_r <= 8'h00;
            wait_r <= 1'b0;
        end else begin
            pad_r <= pad_nxt;
            p4_prev_r <= pin_in[P_AD];
            ad_in_r <= pin_in[P_AD];
            wait_r <= pin_in[P_CTL][WAIT_PIN];
        end
    end

    // Interrupt edge detectors on port 0
    ppc_edge_det u_edge (
        .ref_clk(ref_clk),
        .srst(srst),
        .pin(pin_in[P_IRQ][NIRQ-1:0]),
        .rise_en(rise_r),
        .fall_en(fall_r),
        .irq_req(ext_irq_inputs)
    );

    // ************************************************************
    // Outputs
    // ************************************************************
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign pad_o = pad_r;
    assign ext_ad_in = ad_in_r;
    assign ext_wait = wait_r;
    assign port_edge_test_flag = flag_r;
    assign sub_osc_feedback_cut = pcc_r[PCC_FRC];

    // ************************************************************
    // Checks
    // ************************************************************
    AST_RESET_INPUT: assert property (@(posedge ref_clk)
        srst |=> pad_r[P_AD].oe_n == 8'hff && pad_r[P_HA].oe_n == 8'hff)
        else $error("pin driven right after reset");
    AST_FLAG_SET: assert property (@(posedge ref_clk) disable iff (srst)
        (p4_prev_r & ~pin_in[P_AD]) != 8'h00 |=> flag_r)
        else $error("falling edge on port 4 did not set the flag");
    AST_P4_DIR_UNIT: assert property (@(posedge ref_clk) disable iff (srst)
        dir_r[P_AD] == 8'h00 || dir_r[P_AD] == 8'hff)
        else $error("port 4 direction split");
    AST_P1_PULL_OFF: assert property (@(posedge ref_clk) disable iff (srst)
        ctrl_r[CTRL_ADC] |=> pad_r[P_AN].pull == 8'h00)
        else $error("port 1 pull-up on in analog use");
    AST_PULL_INPUT_ONLY: assert property (@(posedge ref_clk) disable iff (srst)
        (pad_r[2].pull & ~pad_r[2].oe_n) == 8'h00)
        else $error("pull-up on a driven pin");
    AST_WIDTH: assert property (@(posedge ref_clk) disable iff (srst)
        pad_r[7].oe_n[7:3] == 5'h1f && pad_r[9].oe_n[7:2] == 6'h3f)
        else $error("missing pin driven");
    AST_OD_PULL: assert property (@(posedge ref_clk) disable iff (srst)
        !srst ##1 !srst |-> pad_r[P_CTL].pull[3:0] == OD_PULLUP)
        else $error("open-drain pull-up not fixed");
    AST_HIGH_ADDR: assert property (@(posedge ref_clk) disable iff (srst)
        ctrl_r[CTRL_MEXP] |=> pad_r[P_HA].oe_n == 8'h00
        && pad_r[P_HA].dout == $past(ext_i.addr[15:8]))
        else $error("high address not on port 5");
    AST_P6_STROBE: assert property (@(posedge ref_clk) disable iff (srst)
        ctrl_r[CTRL_MEXP] |=> pad_r[P_CTL].dout[4] == $past(ext_i.rd)
        && pad_r[P_CTL].dout[7] == $past(ext_i.address_latch_strobe) && pad_r[P_CTL].oe_n[6])
        else $error("expansion strobes wrong on port 6");
    COV_WRITE: cover property (@(posedge ref_clk) do_wr && bresp_nxt == RESP_OKAY);
    COV_FLAG: cover property (@(posedge ref_clk) !flag_r ##1 flag_r);
    COV_MEXP: cover property (@(posedge ref_clk) ctrl_r[CTRL_MEXP] && ext_i.ad_oe);

endmodule

// ### verification/ppc_board_model.sv
/* Board model: each pin shows the pad drive, else the pull-up, else a
   board level set by the bench. Assumes pads sampled on ref_clk. */
`timescale 1ns/1ps
module ppc_board_model (
    // Pads and board levels
    input ppc_pkg::ppc_pad_s [ppc_pkg::NPORT-1:0] pad_o,
    input wire logic [ppc_pkg::NPORT-1:0][7:0] brd_lvl,
    // Resolved pins
    output logic [ppc_pkg::NPORT-1:0][7:0] pin_in
);
    import ppc_pkg::*;
    // Drive wins, then pull-up, then board
    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            for (int b = 0; b < 8; b++) begin
                pin_in[p][b] = !pad_o[p].oe_n[b] ? pad_o[p].dout[b] :
                    (pad_o[p].pull[b] ? 1'b1 : brd_lvl[p][b]);
            end
        end
    end
endmodule

// ### verification/tb_top.sv
/* Directed bench: AXI4-Lite tasks drive the port block.
   Assumes the board model closes the pin loop. */
`timescale 1ns/1ps
module tb_top;
    import ppc_pkg::*;
    logic ref_clk = 1'b0, srst = 1'b1, awv = 1'b0, wv = 1'b0, arv = 1'b0;
    logic [3:0] seen = 4'h0; // Request pulses counted on pin 1
    logic awr, wrd, bv, arr, rv, flag, fcut;
    logic [11:0] aw = '0, ar = '0;
    logic [31:0] wd = '0, rdat;
    logic [1:0] br, rr;
    logic [6:0] irq;
    logic [9:0][7:0] brd = '1, pin;
    ppc_pad_s [9:0] pad;
    ppc_ext_s ext = '0; // External bus controller request
    logic [7:0] adin;
    logic ewait;
    int errors = 0, samples_checked = 0, cyc = 0;
    always #2.5 ref_clk = ~ref_clk;
    ppc_top ppc_top_i (.ref_clk(ref_clk), .srst(srst), .s_axi_awaddr(aw),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(1'b1), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
        .pin_in(pin), .pad_o(pad), .ext_i(ext), .ext_ad_in(adin), .ext_wait(ewait),
        .ext_irq_inputs(irq), .port_edge_test_flag(flag), .sub_osc_feedback_cut(fcut));
    ppc_board_model ppc_board_model_i (.pad_o(pad), .brd_lvl(brd), .pin_in(pin));
    // ************************************************************
    // Tasks
    // ************************************************************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        aw <= a;
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
        end while (!bv);
    endtask
    task rc(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
        ar <= a;
        arv <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        chk(rdat, {24'h0, d});
        chk({30'h0, rr}, {30'h0, r});
    endtask
    task idle;
        repeat (2) @(posedge ref_clk);
    endtask
    task final_report;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Catch a one-cycle request pulse
    always @(posedge ref_clk) if (irq[1]) seen <= seen + 4'h1;
    // Hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            final_report;
        end
    end
    // Main sequence
    initial begin
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        idle;
        rc(12'h024, 8'hff, RESP_OKAY);
        chk(pad[2].oe_n, 8'hff);
        wr(12'h028, 8'hff);
        wr(12'h024, 8'h0f);
        wr(12'h020, 8'ha5);
        idle;
        chk(pad[2].pull, 8'h0f);
        chk(pad[2].oe_n, 8'h0f);
        rc(12'h020, 8'haf, RESP_OKAY);
        wr(12'h014, 8'hff);
        wr(12'h100, 8'h02);
        wr(12'h018, 8'hff);
        idle;
        chk(pad[1].pull, 8'h00);
        wr(12'h100, 8'h00);
        brd[4] <= 8'h7f;
        idle;
        rc(12'h104, 8'h01, RESP_OKAY);
        wr(12'h104, 8'h01);
        rc(12'h104, 8'h00, RESP_OKAY);
        wr(12'h044, 8'hfe);
        idle;
        chk(pad[4].oe_n, 8'h00);
        wr(12'h074, 8'h00);
        wr(12'h070, 8'hff);
        rc(12'h070, 8'h07, RESP_OKAY);
        wr(12'h10c, 8'h02);
        brd[0][1] <= 1'b0;
        idle;
        idle;
        chk(seen, 32'h1);
        wr(12'h108, 8'h02);
        brd[0][1] <= 1'b1;
        idle;
        idle;
        chk(seen, 32'h2);
        wr(12'h110, 8'h40);
        chk(fcut, 1'b1);
        wr(12'h100, 8'h01);
        ext <= '{16'hc300, 8'h3c, 1'b1, 1'b1, 1'b0, 1'b0};
        brd[6][6] <= 1'b0;
        idle;
        idle;
        chk(pad[5].dout, 8'hc3);
        chk(pad[5].oe_n, 8'h00);
        chk(pad[6].dout, 8'h10);
        chk(pad[6].oe_n, 8'h4f);
        chk(adin, 8'h3c);
        chk(ewait, 1'b0);
        rc(12'h200, 8'h00, RESP_SLVERR);
        final_report;
    end
endmodule
